// *** verilog/pd_timing_pkg.sv ***
// timing constants, command codes and states for the power-down and
// command bus training sequencer; assumes a 20 MHz controller clock.
`default_nettype none
package pd_timing_pkg;
	localparam int TCK_PS = 50000;
	localparam int CNT_W = 8;
	localparam int CA_W = 6;
	typedef logic [CNT_W-1:0] cnt_t;
	typedef logic [CA_W-1:0] ca_t;

	// printed limits, in picoseconds, some with a cycle floor
	localparam int T_CKELCS_PS = 5000;
	localparam int N_CKELCS = 5;
	localparam int T_CKCKEH_PS = 1750;
	localparam int N_CKCKEH = 3;
	localparam int T_XP_PS = 7500;
	localparam int N_XP = 5;
	localparam int T_CSCKEH_PS = 1750;
	localparam int T_CKEHCS_PS = 7500;
	localparam int N_CKEHCS = 5;
	localparam int T_MRWCKEL_PS = 14000;
	localparam int N_MRWCKEL = 10;
	localparam int T_ZQCKE_PS = 1750;
	localparam int N_ZQCKE = 3;
	// row-to-column delay is not given here; plain default
	localparam int T_RCD_PS = 18000;
	localparam int N_MRRI_EXTRA = 3;
	localparam int N_MRR = 8;
	localparam int T_MRW_PS = 10000;
	localparam int N_MRW = 10;
	localparam int T_MRD_PS = 14000;
	localparam int N_MRD = 10;
	localparam int T_ADR_PS = 20000;
	localparam int T_DQSCKE_PS = 10000;
	localparam int T_CAENT_PS = 250000;
	localparam int T_VREF_LONG_PS = 250000;
	localparam int T_VREF_SHORT_PS = 80000;
	localparam int N_CKPRECS_EXTRA = 2;
	localparam int T_CKELCK_PS = 5000;
	localparam int N_CKELCK = 5;
	localparam int T_CKPSTCS_PS = 7500;
	localparam int N_CKPSTCS = 5;

	function automatic int imax(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	// round a time up to whole cycles, never below one, then apply floor
	function automatic int cyc(input int ps, input int nck);
		int c;
		c = (ps + TCK_PS - 1) / TCK_PS;
		if (c < 1) begin
			c = 1;
		end
		return imax(c, nck);
	endfunction

	localparam cnt_t CYC_CKELCS = cnt_t'(cyc(T_CKELCS_PS, N_CKELCS));
	localparam cnt_t CYC_CKCKEH = cnt_t'(imax(cyc(T_CKCKEH_PS, N_CKCKEH),
		cyc(T_CSCKEH_PS, 1)));
	localparam int XP_I = cyc(T_XP_PS, N_XP);
	localparam cnt_t CYC_PDX = cnt_t'(imax(XP_I,
		cyc(T_CKEHCS_PS, N_CKEHCS)));
	localparam cnt_t CYC_MRWCKEL = cnt_t'(cyc(T_MRWCKEL_PS, N_MRWCKEL));
	localparam cnt_t CYC_ZQCKE = cnt_t'(cyc(T_ZQCKE_PS, N_ZQCKE));
	localparam cnt_t CYC_MRRI = cnt_t'(cyc(T_RCD_PS, 1) + N_MRRI_EXTRA);
	localparam cnt_t CYC_MRR = cnt_t'(N_MRR);
	localparam cnt_t CYC_MRW = cnt_t'(imax(cyc(T_MRW_PS, N_MRW),
		cyc(T_MRD_PS, N_MRD)));
	localparam cnt_t CYC_CMD = cnt_t'(1);
	localparam cnt_t CYC_CACD = cnt_t'(imax(cyc(T_ADR_PS, 1),
		cyc(T_CKPSTCS_PS, N_CKPSTCS)));
	localparam cnt_t CYC_DQSCKE = cnt_t'(cyc(T_DQSCKE_PS, 1));
	localparam cnt_t CYC_CBT_ENTRY = cnt_t'(imax(imax(
		cyc(T_CAENT_PS, 1), cyc(T_CKELCK_PS, N_CKELCK)),
		N_CKPRECS_EXTRA + XP_I));
	localparam cnt_t CYC_VREF_LONG = cnt_t'(imax(cyc(T_VREF_LONG_PS, 1),
		cyc(T_CKPSTCS_PS, N_CKPSTCS)));
	localparam cnt_t CYC_VREF_SHORT = cnt_t'(imax(cyc(T_VREF_SHORT_PS, 1),
		cyc(T_CKPSTCS_PS, N_CKPSTCS)));

	typedef enum logic [3:0] {
		OP_CMD,
		OP_MRR,
		OP_MRW,
		OP_ZQ_START,
		OP_PD_ENTER,
		OP_PD_EXIT,
		OP_CBT_ENTER,
		OP_CBT_CMD,
		OP_VREF_SHORT,
		OP_VREF_LONG,
		OP_CBT_EXIT
	} op_t;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_GAP,
		ST_PDE_HOLD,
		ST_PD,
		ST_PDX_CLK,
		ST_PDX_HOLD,
		ST_CBT_STROBE,
		ST_CBT_ENTRY,
		ST_CBT,
		ST_CBT_GAP
	} state_t;
endpackage
`default_nettype wire

// *** verilog/wait_if.sv ***
// load and done signals between the sequencer and its wait counter;
// both ends sit on the same clock.
`default_nettype none
interface wait_if;
	import pd_timing_pkg::*;
	logic load;
	cnt_t count;
	logic done;
	modport ctl (output load, output count, input done);
	modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

// *** verilog/wait_timer.sv ***
// down counter for the sequencer's waits; done is high once count
// cycles have passed since the load, and stays high until the next load.
`default_nettype none
module wait_timer (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	wait_if.tmr w
);
	import pd_timing_pkg::*;
	cnt_t cnt_reg;
	wire cnt_zero = (cnt_reg == '0);

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_reg <= '0;
		end else if (w.load) begin
			cnt_reg <= w.count - cnt_t'(1);
		end else if (!cnt_zero) begin
			cnt_reg <= cnt_reg - cnt_t'(1);
		end
	end

	// done ignores load on purpose: the sequencer loads on done, so a
	// load term here would close a combinational loop through the fsm
	assign w.done = cnt_zero;
endmodule
`default_nettype wire

// *** verilog/pd_sequencer.sv ***
// controller-side sequencer for power-down, mode register access and
// command bus training; drives cke, cs, ca, clock enable and strobe enable.
// assumes the user port runs on ref_clk_in; the pins go to the memory.
// Behaviour
// - after cke low keep cs valid max(5 ns, 5 cycles)
// - run clock max(1.75 ns, 3 cycles) before raising cke on exit
// - after power-down exit wait max(7.5 ns, 5 cycles) before command
// - hold cs valid at least 1.75 ns before raising cke
// - after raising cke keep cs valid max(7.5 ns, 5 cycles)
// - cke low after mode write: clock and cs valid max(14 ns, 10)
// - cke low after calibration start: clock and cs valid max(1.75 ns, 3)
// - after exit delay, wait row-to-column delay plus 3 before mode read
// - mode read to next command at least 8 cycles
// - mode write to next command max(10 ns, 10 cycles)
// - after mode set wait max(14 ns, 10 cycles) before dependent command
// - training commands spaced by 20 ns read time rounded up to cycles
// - strobe valid 10 ns before cke low for training entry
// - first training command no sooner than 250 ns after cke low
// - multi-step reference change settles up to 250 ns before use
// - single-step reference change settles up to 80 ns before use
// - clock valid 2 cycles plus exit time before cs high in training
// - clock runs max(5 ns, 5 cycles) after cke low on training entry
// - clock valid max(7.5 ns, 5 cycles) after cs high in training
`default_nettype none
module pd_sequencer (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic cmd_valid_in,
	input wire pd_timing_pkg::op_t cmd_op_in,
	input wire pd_timing_pkg::ca_t cmd_ca_in,
	output logic cmd_ready_out,
	output logic cke_out,
	output logic cs_out,
	output pd_timing_pkg::ca_t ca_out,
	output logic ck_en_out,
	output logic strobe_oe_out,
	output logic pd_active_out,
	output logic cbt_active_out
);
	import pd_timing_pkg::*;

	state_t state_reg;
	state_t state_next;
	logic cke_reg;
	logic cke_next;
	logic cs_reg;
	logic cs_next;
	ca_t ca_reg;
	ca_t ca_next;
	logic ck_en_reg;
	logic ck_en_next;
	logic strobe_oe_reg;
	logic strobe_oe_next;
	op_t last_reg;
	op_t last_next;
	cnt_t mrri_reg;
	logic mrri_arm;
	logic tmr_load;
	cnt_t tmr_count;

	wait_if w ();

	wait_timer u_wait (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.w(w)
	);

	assign w.load = tmr_load;
	assign w.count = tmr_count;

	// decode of the request against the current state
	wire in_idle = (state_reg == ST_IDLE);
	wire in_pd = (state_reg == ST_PD);
	wire in_cbt = (state_reg == ST_CBT);
	wire mrri_busy = (mrri_reg != '0);
	wire op_mrr = (cmd_op_in == OP_MRR);
	wire mrr_blocked = op_mrr && mrri_busy;
	wire take = cmd_valid_in && cmd_ready_out;

	// gap after an ordinary command, chosen per command kind
	wire cnt_t cmd_gap = op_mrr ? CYC_MRR :
		(cmd_op_in == OP_MRW) ? CYC_MRW :
		CYC_CMD;

	// clock and cs hold after cke low depends on the last command
	wire cnt_t pde_hold = (last_reg == OP_MRW) ? CYC_MRWCKEL :
		(last_reg == OP_ZQ_START) ? CYC_ZQCKE :
		CYC_CKELCS;

	// training step gap: read time or settling of the reference level
	wire cnt_t cbt_gap = (cmd_op_in == OP_VREF_LONG) ?
		CYC_VREF_LONG :
		(cmd_op_in == OP_VREF_SHORT) ? CYC_VREF_SHORT :
		CYC_CACD;

	// ready is combinational so a request is taken in the cycle it shows;
	// only a mode read is held back while the post-exit wait still runs
	assign cmd_ready_out = (in_idle && !mrr_blocked) || in_pd || in_cbt;

	always_comb begin
		state_next = state_reg;
		cke_next = cke_reg;
		cs_next = 1'b0;
		ca_next = ca_reg;
		ck_en_next = ck_en_reg;
		strobe_oe_next = strobe_oe_reg;
		last_next = last_reg;
		mrri_arm = 1'b0;
		tmr_load = 1'b0;
		tmr_count = '0;
		case (state_reg)
			ST_IDLE: begin
				if (take) begin
					case (cmd_op_in)
						OP_PD_ENTER: begin
							cke_next = 1'b0;
							tmr_load = 1'b1;
							tmr_count = pde_hold;
							state_next = ST_PDE_HOLD;
						end
						OP_CBT_ENTER: begin
							strobe_oe_next = 1'b1;
							tmr_load = 1'b1;
							tmr_count = CYC_DQSCKE;
							state_next = ST_CBT_STROBE;
						end
						OP_CMD, OP_MRR, OP_MRW, OP_ZQ_START: begin
							cs_next = 1'b1;
							ca_next = cmd_ca_in;
							last_next = cmd_op_in;
							tmr_load = 1'b1;
							tmr_count = cmd_gap;
							state_next = ST_GAP;
						end
						default: begin
							state_next = ST_IDLE;
						end
					endcase
				end
			end
			ST_GAP: begin
				if (w.done) begin
					state_next = ST_IDLE;
				end
			end
			ST_PDE_HOLD: begin
				// clock and cs stay valid until the hold has run out
				if (w.done) begin
					ck_en_next = 1'b0;
					state_next = ST_PD;
				end
			end
			ST_PD: begin
				if (take && cmd_op_in == OP_PD_EXIT) begin
					ck_en_next = 1'b1;
					tmr_load = 1'b1;
					tmr_count = CYC_CKCKEH;
					state_next = ST_PDX_CLK;
				end
			end
			ST_PDX_CLK: begin
				if (w.done) begin
					cke_next = 1'b1;
					tmr_load = 1'b1;
					tmr_count = CYC_PDX;
					state_next = ST_PDX_HOLD;
				end
			end
			ST_PDX_HOLD: begin
				if (w.done) begin
					mrri_arm = 1'b1;
					last_next = OP_CMD;
					state_next = ST_IDLE;
				end
			end
			ST_CBT_STROBE: begin
				if (w.done) begin
					cke_next = 1'b0;
					tmr_load = 1'b1;
					// clock keeps running through entry and all of training
					tmr_count = CYC_CBT_ENTRY;
					state_next = ST_CBT_ENTRY;
				end
			end
			ST_CBT_ENTRY: begin
				if (w.done) begin
					state_next = ST_CBT;
				end
			end
			ST_CBT: begin
				if (take) begin
					case (cmd_op_in)
						OP_CBT_CMD, OP_VREF_SHORT, OP_VREF_LONG: begin
							cs_next = 1'b1;
							ca_next = cmd_ca_in;
							tmr_load = 1'b1;
							tmr_count = cbt_gap;
							state_next = ST_CBT_GAP;
						end
						OP_CBT_EXIT: begin
							cke_next = 1'b1;
							strobe_oe_next = 1'b0;
							tmr_load = 1'b1;
							tmr_count = CYC_PDX;
							state_next = ST_PDX_HOLD;
						end
						default: begin
							state_next = ST_CBT;
						end
					endcase
				end
			end
			ST_CBT_GAP: begin
				if (w.done) begin
					state_next = ST_CBT;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// one short register per signal, state and last command included, keeps each reset value in sight
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// cke and the clock come up high, so leaving reset never looks like
	// a power-down entry to the memory
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cke_reg <= 1'b1;
		end else begin
			cke_reg <= cke_next;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cs_reg <= 1'b0;
		end else begin
			cs_reg <= cs_next;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ca_reg <= '0;
		end else begin
			ca_reg <= ca_next;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ck_en_reg <= 1'b1;
		end else begin
			ck_en_reg <= ck_en_next;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			strobe_oe_reg <= 1'b0;
		end else begin
			strobe_oe_reg <= strobe_oe_next;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			last_reg <= OP_CMD;
		end else begin
			last_reg <= last_next;
		end
	end

	// extra wait before a mode read once the exit delay is over; other
	// commands may go meanwhile, so it runs beside the main timer
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mrri_reg <= '0;
		end else if (mrri_arm) begin
			mrri_reg <= CYC_MRRI;
		end else if (mrri_busy) begin
			mrri_reg <= mrri_reg - cnt_t'(1);
		end
	end

	assign cke_out = cke_reg;
	assign cs_out = cs_reg;
	assign ca_out = ca_reg;
	assign ck_en_out = ck_en_reg;
	assign strobe_oe_out = strobe_oe_reg;
	assign pd_active_out = in_pd;
	assign cbt_active_out = in_cbt;
endmodule
`default_nettype wire

// *** sim/pd_seq_properties.sv ***
// timing assertions on the sequencer's pins.
// assumes it is bound to pd_sequencer and sees only its ports.
`default_nettype none
module pd_seq_properties (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic cmd_valid_in,
	input wire pd_timing_pkg::op_t cmd_op_in,
	input wire pd_timing_pkg::ca_t cmd_ca_in,
	input wire logic cmd_ready_out,
	input wire logic cke_out,
	input wire logic cs_out,
	input wire pd_timing_pkg::ca_t ca_out,
	input wire logic ck_en_out,
	input wire logic strobe_oe_out,
	input wire logic pd_active_out,
	input wire logic cbt_active_out
);
	import pd_timing_pkg::*;
	op_t last_reg;
	wire logic take = cmd_valid_in && cmd_ready_out;
	wire logic idle_take = take && !pd_active_out && !cbt_active_out;
	wire logic pd_fall_mrw = !strobe_oe_out && last_reg == OP_MRW;
	wire logic pd_fall_zq = !strobe_oe_out && last_reg == OP_ZQ_START;
	wire logic pd_fall_std = !strobe_oe_out && !pd_fall_mrw && !pd_fall_zq;
	// the hold before clock stop depends on the last command issued
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			last_reg <= OP_CMD;
		end else if (take && cmd_op_in != OP_PD_ENTER) begin
			last_reg <= cmd_op_in;
		end
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence quiet5;
		(ck_en_out && !cs_out)[*5];
	endsequence
	sequence mrr_issue;
		cs_out ##1 (!cs_out)[*8];
	endsequence
	sequence mrw_issue;
		cs_out ##1 (!cs_out)[*5] ##1 (!cs_out)[*5];
	endsequence
	sequence mrr_take;
		idle_take && cmd_op_in == OP_MRR;
	endsequence
	sequence mrw_take;
		idle_take && cmd_op_in == OP_MRW;
	endsequence
	sequence cbt_enter;
		$fell(cke_out) && strobe_oe_out;
	endsequence
	pd_hold_a: assert property ($fell(cke_out) && pd_fall_std |->
		quiet5 ##1 !ck_en_out) else $error("clock stop after cke low");
	pd_mrw_a: assert property ($fell(cke_out) && pd_fall_mrw |->
		quiet5 ##1 quiet5 ##1 !ck_en_out) else $error("mrw hold");
	pd_zq_a: assert property ($fell(cke_out) && pd_fall_zq |->
		(ck_en_out && !cs_out)[*3] ##1 !ck_en_out) else $error("zq hold");
	exit_clock_a: assert property ($rose(cke_out) |->
		$past(ck_en_out, 3)) else $error("clock late before cke high");
	exit_cs_a: assert property ($rose(cke_out) |->
		(!cs_out)[*5]) else $error("command too soon after cke high");
	mrr_wait_a: assert property ($rose(cke_out) |->
		(!(take && cmd_op_in == OP_MRR))[*8]) else $error("mode read early");
	mrr_gap_a: assert property (mrr_take |=>
		mrr_issue) else $error("mode read spacing");
	mrw_gap_a: assert property (mrw_take |=>
		mrw_issue) else $error("mode write spacing");
	cbt_strobe_a: assert property (cbt_enter |->
		$past(strobe_oe_out)) else $error("strobe late");
	cbt_entry_a: assert property (cbt_enter |->
		(ck_en_out && !cs_out)[*7]) else $error("training entry");
	cbt_gap_a: assert property (cs_out && strobe_oe_out |=>
		(!cs_out && ck_en_out)[*4] ##1 ck_en_out) else $error("training gap");
endmodule
`default_nettype wire

// *** sim/lpddr_model.sv ***
// memory-side model: echoes the training command on its data lines.
// assumes the clock reaches it only while ck_en_in is high.
`default_nettype none
module lpddr_model (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic cke_in,
	input wire logic cs_in,
	input wire pd_timing_pkg::ca_t ca_in,
	input wire logic ck_en_in,
	input wire logic strobe_oe_in,
	output pd_timing_pkg::ca_t train_dq_out
);
	import pd_timing_pkg::*;
	logic in_cbt_reg;
	ca_t cap_reg;
	// released lines show the inverse, so a stale value never matches
	assign train_dq_out = in_cbt_reg ? cap_reg : ~cap_reg;
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			in_cbt_reg <= 1'b0;
			cap_reg <= 6'h00;
		end else if (ck_en_in) begin
			if (!cke_in && strobe_oe_in) begin
				in_cbt_reg <= 1'b1;
			end else if (cke_in) begin
				in_cbt_reg <= 1'b0;
			end
			if (cs_in && in_cbt_reg) begin
				cap_reg <= ca_in;
			end
		end
	end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// bench for the power-down and training sequencer.
// assumes the sequencer and a memory model on its pins.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import pd_timing_pkg::*;
	logic ref_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic cmd_valid_in = 1'b0;
	op_t cmd_op_in = OP_CMD;
	ca_t cmd_ca_in = 6'h00;
	logic cmd_ready_out, cke_out, cs_out, ck_en_out, strobe_oe_out;
	logic pd_active_out, cbt_active_out;
	ca_t ca_out, train_dq;
	int failures = 0, n_tests = 0, cyc = 0;
	int t_cs0 = 0, t_cs1 = 0, t_kf = 0, t_kr = 0, t_cf = 0, t_cr = 0, t_sr = 0;
	logic k_q = 1'b1, c_q = 1'b1, s_q = 1'b0;
	always #25 ref_clk_in = ~ref_clk_in;
	pd_sequencer dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
		.cmd_ca_in(cmd_ca_in), .cmd_ready_out(cmd_ready_out),
		.cke_out(cke_out), .cs_out(cs_out), .ca_out(ca_out),
		.ck_en_out(ck_en_out), .strobe_oe_out(strobe_oe_out),
		.pd_active_out(pd_active_out), .cbt_active_out(cbt_active_out));
	lpddr_model mem (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.cke_in(cke_out), .cs_in(cs_out), .ca_in(ca_out),
		.ck_en_in(ck_en_out), .strobe_oe_in(strobe_oe_out),
		.train_dq_out(train_dq));
	task automatic give_verdict;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// edge times in cycles, all taken at the same sampling edge
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cs_out === 1'b1) begin
			t_cs0 <= t_cs1;
			t_cs1 <= cyc;
		end
		if (k_q && !cke_out) t_kf <= cyc;
		if (!k_q && cke_out) t_kr <= cyc;
		if (c_q && !ck_en_out) t_cf <= cyc;
		if (!c_q && ck_en_out) t_cr <= cyc;
		if (!s_q && strobe_oe_out) t_sr <= cyc;
		k_q <= cke_out;
		c_q <= ck_en_out;
		s_q <= strobe_oe_out;
		if (cyc > 4000) begin
			failures = failures + 1;
			give_verdict();
		end
	end
	task automatic chk(input bit ok, input string msg);
		n_tests++;
		if (!ok) begin
			failures++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	// holds the request until the edge that takes it
	task automatic issue(input op_t op, input ca_t ca);
		int n;
		n = 0;
		@(negedge ref_clk_in);
		cmd_valid_in = 1'b1;
		cmd_op_in = op;
		cmd_ca_in = ca;
		// let ready settle on the new op before it is looked at
		#1;
		while (cmd_ready_out !== 1'b1 && n < 300) begin
			@(negedge ref_clk_in);
			n++;
		end
		chk(n < 300, "request never taken");
		@(negedge ref_clk_in);
		cmd_valid_in = 1'b0;
	endtask
	task automatic pd_case(input op_t pre, input int hold);
		issue(pre, 6'h11);
		issue(OP_PD_ENTER, 6'h00);
		repeat (hold - 1) @(negedge ref_clk_in);
		chk(pd_active_out === 1'b0, "power-down too early");
		@(negedge ref_clk_in);
		chk(pd_active_out === 1'b1, "power-down missed");
		issue(OP_PD_EXIT, 6'h00);
		chk(t_cf - t_kf == hold, "clock stop hold");
		chk(t_cs1 < t_kf, "command during power-down");
		issue(OP_MRR, 6'h05);
		@(negedge ref_clk_in);
		chk(t_kr - t_cr == 3, "clock before cke high");
		chk(t_cs1 - t_kr >= 9, "mode read after exit");
		$display("test power-down hold %0d done", hold);
	endtask
	task automatic mode_gaps;
		issue(OP_MRR, 6'h0A);
		issue(OP_CMD, 6'h01);
		@(negedge ref_clk_in);
		chk(t_cs1 - t_cs0 >= 8, "mode read spacing");
		issue(OP_MRW, 6'h3C);
		chk(ca_out === 6'h3C, "mode write payload");
		issue(OP_CMD, 6'h02);
		@(negedge ref_clk_in);
		chk(t_cs1 - t_cs0 >= 10, "mode write spacing");
		$display("test mode gaps done");
	endtask
	task automatic cbt_flow;
		issue(OP_CBT_ENTER, 6'h00);
		repeat (7) @(negedge ref_clk_in);
		chk(cbt_active_out === 1'b0, "training too early");
		@(negedge ref_clk_in);
		chk(cbt_active_out === 1'b1, "training missed");
		issue(OP_CBT_CMD, 6'h15);
		@(negedge ref_clk_in);
		chk(t_kf - t_sr >= 1, "strobe before cke low");
		chk(t_cs1 - t_kf >= 7, "first training command");
		chk(train_dq === 6'h15, "training echo");
		issue(OP_CBT_CMD, 6'h2A);
		@(negedge ref_clk_in);
		chk(t_cs1 - t_cs0 >= 5, "training spacing");
		chk(train_dq === 6'h2A, "second echo");
		issue(OP_VREF_SHORT, 6'h01);
		issue(OP_CBT_CMD, 6'h03);
		@(negedge ref_clk_in);
		chk(t_cs1 - t_cs0 >= 2, "short settle");
		issue(OP_VREF_LONG, 6'h07);
		issue(OP_CBT_CMD, 6'h04);
		@(negedge ref_clk_in);
		chk(t_cs1 - t_cs0 >= 5, "long settle");
		issue(OP_CBT_EXIT, 6'h00);
		chk(t_cf < t_kf, "clock stopped in training");
		issue(OP_CMD, 6'h09);
		@(negedge ref_clk_in);
		chk(t_cs1 - t_kr >= 5, "command after training exit");
		chk(cke_out === 1'b1, "cke after training exit");
		$display("test training done");
	endtask
	initial begin
		repeat (20) @(negedge ref_clk_in);
		rst_n_in = 1'b1;
		pd_case(OP_CMD, 5);
		pd_case(OP_MRW, 10);
		pd_case(OP_ZQ_START, 3);
		mode_gaps();
		cbt_flow();
		give_verdict();
	end
endmodule
bind pd_sequencer pd_seq_properties props (.ref_clk_in(ref_clk_in),
	.rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
	.cmd_op_in(cmd_op_in), .cmd_ca_in(cmd_ca_in),
	.cmd_ready_out(cmd_ready_out), .cke_out(cke_out), .cs_out(cs_out),
	.ca_out(ca_out), .ck_en_out(ck_en_out), .strobe_oe_out(strobe_oe_out),
	.pd_active_out(pd_active_out), .cbt_active_out(cbt_active_out));
`default_nettype wire
